// ==== common/vga_gc_pkg.sv ====
// How it works
// - Two-bit write mode selects one of four host write behaviours.
// - Write mode 0 rotates the host byte before it feeds the planes not using set/reset.
// - Mode 0 planes with set/reset enabled take the replicated set/reset bit.
// - Extended bypass bit makes mode 0 use host data for every plane.
// - Mode 0 combines set/reset output with latches by function select.
// - Modes 0 and 2 write only enabled planes and enabled bit positions.
// - Mode 1 writes the latches to the enabled planes and ignores the bit mask.
// - Mode 2 replicates host bits 3..0 across bytes of planes 3..0.
// - Mode 2 bypasses rotator, set/reset and function select.
// - Mode 3 plane data is the replicated set/reset value bit.
// - Mode 3 bit enable is bit mask AND the rotated host byte.
// - Memory map field decodes the host aperture base and length.
// - Odd/even chaining steers even addresses to planes 0,2 and odd to 1,3.
// - Graphics-mode bit selects points-addressable graphics or text operation.
// - Compare-include bit zero makes that plane always match.
// - Bit mask bit one allows writing that bit, zero preserves it.
// - Bit mask and plane enable protection apply independently.
// - Function select: 00 pass, 01 AND, 10 OR, 11 XOR with latch byte.
// - Read mode 0 returns the byte of the selected plane.
// - Read mode 1 returns one per bit where included planes match color.
package vga_gc_pkg;

  // ------------------------------------------------------------
  // Register indices and reset values
  // ------------------------------------------------------------
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_MISC = 6'h06;
  localparam logic [5:0] IDX_CMP = 6'h07;
  localparam logic [5:0] IDX_MASK = 6'h08;
  localparam logic [5:0] IDX_RST = 6'h00;
  localparam logic [3:0] MISC_RST = 4'h0;
  localparam logic [3:0] CMP_RST = 4'h0;
  localparam logic [7:0] MASK_RST = 8'hFF;

  // ------------------------------------------------------------
  // Field positions of the miscellaneous register
  // ------------------------------------------------------------
  localparam int MISC_GFX_BIT = 0;
  localparam int MISC_CHAIN_BIT = 1;
  localparam int MISC_MAP_LSB = 2;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] MAP_A000_128K = 2'h0;
  localparam logic [1:0] MAP_A000_64K = 2'h1;
  localparam logic [1:0] MAP_B000_32K = 2'h2;
  localparam logic [1:0] MAP_B800_32K = 2'h3;
  localparam logic [1:0] FSEL_PASS = 2'h0;
  localparam logic [1:0] FSEL_AND = 2'h1;
  localparam logic [1:0] FSEL_OR = 2'h2;
  localparam logic [1:0] FSEL_XOR = 2'h3;
  localparam logic [1:0] WMODE_0 = 2'h0;
  localparam logic [1:0] WMODE_1 = 2'h1;
  localparam logic [1:0] WMODE_2 = 2'h2;
  localparam logic [1:0] WMODE_3 = 2'h3;

  // Control bits owned by neighbouring register groups
  typedef struct packed {
    logic [3:0] set_reset_value;
    logic [3:0] set_reset_enable;
    logic [3:0] compare_color_value;
    logic [1:0] function_select;
    logic [2:0] rotate_count;
    logic [1:0] read_plane_select;
    logic read_mode;
    logic [1:0] write_mode;
    logic [3:0] plane_write_enable;
    logic ext_sr_bypass;
  } cfg_t;

  // One access to the four display memory planes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [3:0] plane_en;
    logic [7:0] bit_mask;
    logic [31:0] data;
  } vram_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RDWAIT = 2'b10
  } state_t;

endpackage

// ==== hw/planar_display_memory_write_read_path.sv ====
`timescale 1ns/1ps
module planar_display_memory_write_read_path #(
  parameter int PLANES = 4
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_io_index_sel,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire vga_gc_pkg::cfg_t i_cfg,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [16:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_hit,
  output logic o_mem_ready,
  output logic o_mem_rvalid,
  output logic [7:0] o_mem_rdata,
  output vga_gc_pkg::vram_req_t o_vram,
  input wire logic [31:0] i_vram_rdata,
  input wire logic i_vram_rvalid,
  output logic o_graphics_mode
);

  // The set/reset, compare and enable fields are four bits wide
  if (PLANES != 4) begin : g_bad_planes
    $error("planar path serves exactly four planes");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  vga_gc_pkg::state_t state_q;
  vga_gc_pkg::state_t state_d;
  logic [5:0] index_q;
  logic [3:0] misc_q;
  logic [3:0] cmp_q;
  logic [7:0] mask_q;
  logic [31:0] latch_q;
  logic [1:0] rsel_q;
  logic rmode_q;

  // ------------------------------------------------------------
  // Index/data register port
  // ------------------------------------------------------------
  wire io_data_wr = i_ce && i_io_wr && !i_io_index_sel;
  wire [7:0] misc_rd = {4'h0, misc_q};
  wire [7:0] cmp_rd = {4'h0, cmp_q};
  // Unknown indices read as zero so other groups can share the port
  wire [7:0] data_rd = (index_q == vga_gc_pkg::IDX_MISC) ? misc_rd :
                       (index_q == vga_gc_pkg::IDX_CMP) ? cmp_rd :
                       (index_q == vga_gc_pkg::IDX_MASK) ? mask_q : 8'h00;
  wire [7:0] io_rd_val = i_io_index_sel ? {2'h0, index_q} : data_rd;

  // Index and control registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      index_q <= vga_gc_pkg::IDX_RST;
      misc_q <= vga_gc_pkg::MISC_RST;
      cmp_q <= vga_gc_pkg::CMP_RST;
      mask_q <= vga_gc_pkg::MASK_RST;
      o_io_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_io_wr && i_io_index_sel) begin
        index_q <= i_io_wdata[5:0];
      end
      if (io_data_wr && index_q == vga_gc_pkg::IDX_MISC) begin
        misc_q <= i_io_wdata[3:0];
      end
      if (io_data_wr && index_q == vga_gc_pkg::IDX_CMP) begin
        cmp_q <= i_io_wdata[3:0];
      end
      if (io_data_wr && index_q == vga_gc_pkg::IDX_MASK) begin
        mask_q <= i_io_wdata;
      end
      if (i_io_rd) begin
        o_io_rdata <= io_rd_val;
      end
    end
  end

  assign o_graphics_mode = misc_q[vga_gc_pkg::MISC_GFX_BIT];

  // ------------------------------------------------------------
  // Host aperture decode and plane addressing
  // ------------------------------------------------------------
  wire [1:0] map = misc_q[vga_gc_pkg::MISC_MAP_LSB +: 2];
  wire chain = misc_q[vga_gc_pkg::MISC_CHAIN_BIT];
  wire hit_64k = !i_mem_addr[16];
  wire hit_b000 = i_mem_addr[16:15] == 2'h2;
  wire hit_b800 = i_mem_addr[16:15] == 2'h3;
  assign o_mem_hit = (map == vga_gc_pkg::MAP_A000_128K) ||
                     (map == vga_gc_pkg::MAP_A000_64K && hit_64k) ||
                     (map == vga_gc_pkg::MAP_B000_32K && hit_b000) ||
                     (map == vga_gc_pkg::MAP_B800_32K && hit_b800);
  wire [16:0] off = (map == vga_gc_pkg::MAP_A000_128K) ? i_mem_addr :
                    (map == vga_gc_pkg::MAP_A000_64K) ? {1'b0, i_mem_addr[15:0]} :
                    {2'h0, i_mem_addr[14:0]};
  // bit 0 swapped for a high bit
  wire [15:0] plane_addr = chain ? {off[15:1], off[16]} : off[15:0];
  wire [3:0] chain_planes = !chain ? 4'hF : (off[0] ? 4'hA : 4'h5);
  wire [1:0] read_plane = chain ? {i_cfg.read_plane_select[1], off[0]} :
                          i_cfg.read_plane_select;

  // ------------------------------------------------------------
  // Request acceptance
  // ------------------------------------------------------------
  // A read holds off new requests until its data returns
  assign o_mem_ready = state_q == vga_gc_pkg::ST_IDLE;
  wire wr_go = i_ce && i_mem_wr && o_mem_hit && o_mem_ready;
  wire rd_go = i_ce && i_mem_rd && !i_mem_wr && o_mem_hit && o_mem_ready;
  wire rd_done = i_ce && i_vram_rvalid && state_q == vga_gc_pkg::ST_RDWAIT;

  // ------------------------------------------------------------
  // Write datapath
  // ------------------------------------------------------------
  wire [15:0] rot_dbl = {i_mem_wdata, i_mem_wdata} >> i_cfg.rotate_count;
  wire [7:0] rot = rot_dbl[7:0];
  wire [1:0] wmode = i_cfg.write_mode;
  wire [1:0] fsel = i_cfg.function_select;
  logic [31:0] wr_data;

  // Per-plane data selection
  for (genvar p = 0; p < PLANES; p++) begin : g_plane
    wire [7:0] latch_b = latch_q[8*p +: 8];
    wire [7:0] srv_b = {8{i_cfg.set_reset_value[p]}};
    wire use_sr = i_cfg.set_reset_enable[p] && !i_cfg.ext_sr_bypass;
    wire [7:0] sr_out = use_sr ? srv_b : rot;
    wire [7:0] alu = (fsel == vga_gc_pkg::FSEL_AND) ? (sr_out & latch_b) :
                     (fsel == vga_gc_pkg::FSEL_OR) ? (sr_out | latch_b) :
                     (fsel == vga_gc_pkg::FSEL_XOR) ? (sr_out ^ latch_b) : sr_out;
    wire [7:0] m2 = {8{i_mem_wdata[p]}};
    assign wr_data[8*p +: 8] = (wmode == vga_gc_pkg::WMODE_0) ? alu :
                               (wmode == vga_gc_pkg::WMODE_1) ? latch_b :
                               (wmode == vga_gc_pkg::WMODE_2) ? m2 : srv_b;
  end

  wire [7:0] wr_mask = (wmode == vga_gc_pkg::WMODE_1) ? 8'hFF :
                       (wmode == vga_gc_pkg::WMODE_3) ? (mask_q & rot) : mask_q;
  wire [3:0] wr_planes = i_cfg.plane_write_enable & chain_planes;

  // ------------------------------------------------------------
  // Read datapath
  // ------------------------------------------------------------
  logic [7:0] cmp_hit;
  // Per-bit colour compare across the planes
  for (genvar b = 0; b < 8; b++) begin : g_bit
    wire [3:0] px = {i_vram_rdata[24+b], i_vram_rdata[16+b],
                     i_vram_rdata[8+b], i_vram_rdata[b]};
    assign cmp_hit[b] = &(~cmp_q | ~(px ^ i_cfg.compare_color_value));
  end
  wire [7:0] plane_byte = i_vram_rdata[8*rsel_q +: 8];
  wire [7:0] rd_val = rmode_q ? cmp_hit : plane_byte;

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      vga_gc_pkg::ST_IDLE: begin
        if (rd_go) begin
          state_d = vga_gc_pkg::ST_RDWAIT;
        end
      end
      vga_gc_pkg::ST_RDWAIT: begin
        if (rd_done) begin
          state_d = vga_gc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = vga_gc_pkg::ST_IDLE;
      end
    endcase
  end

  // Request register toward the planes
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= vga_gc_pkg::ST_IDLE;
      o_vram <= '0;
      rsel_q <= 2'h0;
      rmode_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      o_vram.wr <= wr_go;
      o_vram.rd <= rd_go;
      if (wr_go || rd_go) begin
        o_vram.addr <= plane_addr;
        o_vram.plane_en <= wr_go ? wr_planes : 4'hF;
        o_vram.bit_mask <= wr_go ? wr_mask : 8'h00;
        o_vram.data <= wr_go ? wr_data : 32'h0000_0000;
      end
      if (rd_go) begin
        rsel_q <= read_plane;
        rmode_q <= i_cfg.read_mode;
      end
    end
  end

  // Latches and read return; the latch load ignores read mode
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      latch_q <= 32'h0000_0000;
      o_mem_rdata <= 8'h00;
      o_mem_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_mem_rvalid <= rd_done;
      if (rd_done) begin
        latch_q <= i_vram_rdata;
        o_mem_rdata <= rd_val;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_mode1_latch;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_1 |->
      o_vram.data == $past(latch_q) && o_vram.bit_mask == 8'hFF;
  endproperty
  a_mode1_latch: assert property (p_mode1_latch) else $error("mode 1 data wrong");

  property p_mode0_pass;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_0 &&
    $past(i_cfg.rotate_count) == 3'h0 && $past(fsel) == vga_gc_pkg::FSEL_PASS &&
    $past(i_cfg.ext_sr_bypass) |-> o_vram.data == {4{$past(i_mem_wdata)}};
  endproperty
  a_mode0_pass: assert property (p_mode0_pass) else $error("mode 0 bypass data wrong");

  property p_mode0_rot1;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_0 &&
    $past(i_cfg.rotate_count) == 3'h1 && $past(fsel) == vga_gc_pkg::FSEL_PASS &&
    $past(i_cfg.ext_sr_bypass) |->
      o_vram.data[7:0] == {$past(i_mem_wdata[0]), $past(i_mem_wdata[7:1])};
  endproperty
  a_mode0_rot1: assert property (p_mode0_rot1) else $error("rotate by one wrong");

  property p_mode0_sr;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_0 &&
    $past(i_cfg.set_reset_enable[0]) && !$past(i_cfg.ext_sr_bypass) &&
    $past(fsel) == vga_gc_pkg::FSEL_PASS |->
      o_vram.data[7:0] == {8{$past(i_cfg.set_reset_value[0])}};
  endproperty
  a_mode0_sr: assert property (p_mode0_sr) else $error("set/reset plane 0 wrong");

  property p_mode0_xor;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_0 &&
    $past(fsel) == vga_gc_pkg::FSEL_XOR && $past(i_cfg.ext_sr_bypass) |->
      o_vram.data[15:8] == ($past(rot) ^ $past(latch_q[15:8]));
  endproperty
  a_mode0_xor: assert property (p_mode0_xor) else $error("xor combine wrong");

  property p_mode2_rep;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_2 |->
      o_vram.data[31:24] == {8{$past(i_mem_wdata[3])}} && o_vram.bit_mask == $past(mask_q);
  endproperty
  a_mode2_rep: assert property (p_mode2_rep) else $error("mode 2 plane 3 wrong");

  property p_mode3_mask;
    @(posedge i_mclk) disable iff (i_reset)
    $past(wr_go) && $past(wmode) == vga_gc_pkg::WMODE_3 |->
      o_vram.bit_mask == ($past(mask_q) & $past(rot));
  endproperty
  a_mode3_mask: assert property (p_mode3_mask) else $error("mode 3 bit enable wrong");

  property p_planes;
    @(posedge i_mclk) disable iff (i_reset)
    o_vram.wr && $past(i_ce) |-> (o_vram.plane_en & ~$past(i_cfg.plane_write_enable)) == 4'h0;
  endproperty
  a_planes: assert property (p_planes) else $error("disabled plane written");

  property p_latch_load;
    @(posedge i_mclk) disable iff (i_reset)
    rd_done |=> latch_q == $past(i_vram_rdata) && o_mem_rvalid;
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latches not loaded");

  property p_map3;
    @(posedge i_mclk) disable iff (i_reset)
    i_ce && map == vga_gc_pkg::MAP_B800_32K && !hit_b800 |=> !o_vram.wr && !o_vram.rd;
  endproperty
  a_map3: assert property (p_map3) else $error("access outside aperture");

endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module testbench;
  logic i_mclk, i_reset, i_ce, i_io_wr, i_io_rd, i_io_index_sel, i_mem_wr, i_mem_rd;
  logic [7:0] i_io_wdata, o_io_rdata, i_mem_wdata, o_mem_rdata, q, e, mk;
  logic [16:0] i_mem_addr;
  logic o_mem_hit, o_mem_ready, o_mem_rvalid, o_graphics_mode, i_vram_rvalid;
  logic [31:0] i_vram_rdata, lt, old, w;
  logic [3:0] lat;
  vga_gc_pkg::cfg_t cfg;
  vga_gc_pkg::vram_req_t o_vram;
  int checks_done = 0;
  int n_mismatch = 0;
  logic [16:0] hadr [12] = '{17'h00000, 17'h1FFFF, 17'h10000, 17'h0FFFF, 17'h10000, 17'h00000,
    17'h10000, 17'h17FFF, 17'h18000, 17'h18000, 17'h1FFFF, 17'h17FFF};
  logic [11:0] hexp = 12'b011_011_101_111; // Bit 0 is the first table entry

  planar_display_memory_write_read_path u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_index_sel(i_io_index_sel),
    .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_cfg(cfg), .i_mem_wr(i_mem_wr),
    .i_mem_rd(i_mem_rd), .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata),
    .o_mem_hit(o_mem_hit), .o_mem_ready(o_mem_ready), .o_mem_rvalid(o_mem_rvalid),
    .o_mem_rdata(o_mem_rdata), .o_vram(o_vram), .i_vram_rdata(i_vram_rdata),
    .i_vram_rvalid(i_vram_rvalid), .o_graphics_mode(o_graphics_mode));
  vram_plane_model u_mem (.i_mclk(i_mclk), .i_vram(o_vram), .i_lat(lat), .o_rdata(i_vram_rdata),
    .o_rvalid(i_vram_rvalid));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected planes after one host write, from old contents and latches
  function automatic logic [31:0] ref_wr(logic [31:0] o, logic [31:0] l,
    vga_gc_pkg::cfg_t c, logic [7:0] m, logic [7:0] d);
    logic [15:0] dd;
    logic [7:0] rot, v, bm, lp;
    ref_wr = o;
    dd = {d, d} >> c.rotate_count;
    rot = dd[7:0];
    for (int p = 0; p < 4; p++) begin
      lp = l[p*8+:8];
      bm = m;
      v = (c.ext_sr_bypass || !c.set_reset_enable[p]) ? rot : {8{c.set_reset_value[p]}};
      case (c.function_select)
        2'h1: v = v & lp;
        2'h2: v = v | lp;
        2'h3: v = v ^ lp;
        default: v = v;
      endcase
      if (c.write_mode == 2'h1) begin
        v = lp;
        bm = 8'hFF;
      end else if (c.write_mode == 2'h2) begin
        v = {8{d[p]}};
      end else if (c.write_mode == 2'h3) begin
        v = {8{c.set_reset_value[p]}};
        bm = m & rot;
      end
      if (c.plane_write_enable[p]) ref_wr[p*8+:8] = (o[p*8+:8] & ~bm) | (v & bm);
    end
  endfunction

  task automatic io_op(input logic sel, input logic rd, input logic [7:0] d);
    i_io_index_sel = sel;
    i_io_wdata = d;
    i_io_wr = !rd;
    i_io_rd = rd;
    @(negedge i_mclk);
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    @(negedge i_mclk);
  endtask

  task automatic reg_wr(input logic [5:0] idx, input logic [7:0] d);
    io_op(1'b1, 1'b0, {2'h0, idx});
    io_op(1'b0, 1'b0, d);
  endtask

  task automatic reg_rd(input logic [5:0] idx, output logic [7:0] d);
    io_op(1'b1, 1'b0, {2'h0, idx});
    io_op(1'b0, 1'b1, 8'h00);
    d = o_io_rdata;
  endtask

  // One host memory access; request driven for one cycle once the datapath is ready
  task automatic mem_acc(input logic wr, input logic [16:0] a, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    n = 0;
    while (o_mem_ready !== 1'b1 && n < 50) begin
      @(negedge i_mclk);
      n++;
    end
    i_mem_addr = a;
    i_mem_wdata = d;
    i_mem_wr = wr;
    i_mem_rd = !wr;
    @(negedge i_mclk);
    i_mem_wr = 1'b0;
    i_mem_rd = 1'b0;
    // A taken read blocks further requests until its data returns
    if (!wr) begin
      `CHK("ready during read", 1'b0, o_mem_ready)
    end
    while (!wr && o_mem_rvalid !== 1'b1 && n < 50) begin
      @(negedge i_mclk);
      n++;
    end
    r = o_mem_rdata;
    if (n >= 50) begin
      n_mismatch++;
      close_out();
    end
    @(negedge i_mclk);
  endtask

  initial begin
    {i_reset, i_ce} = 2'b11;
    {i_io_wr, i_io_rd, i_io_index_sel, i_mem_wr, i_mem_rd} = 5'h00;
    {i_io_wdata, i_mem_wdata, i_mem_addr, cfg, lat} = '0;
    repeat (6) @(negedge i_mclk);
    i_reset = 1'b0;
    @(negedge i_mclk);
    reg_rd(vga_gc_pkg::IDX_MISC, q);
    `CHK("misc reset", 8'h00, q)
    reg_rd(vga_gc_pkg::IDX_CMP, q);
    `CHK("include reset", 8'h00, q)
    reg_rd(vga_gc_pkg::IDX_MASK, q);
    `CHK("mask reset", 8'hFF, q)
    reg_rd(6'h05, q);
    `CHK("unmapped read", 8'h00, q)
    reg_wr(vga_gc_pkg::IDX_MISC, 8'hF1);
    reg_rd(vga_gc_pkg::IDX_MISC, q);
    `CHK("misc bits", 8'h01, q)
    `CHK("graphics on", 1'b1, o_graphics_mode)
    reg_wr(vga_gc_pkg::IDX_MISC, 8'h00);
    `CHK("graphics off", 1'b0, o_graphics_mode)
    reg_wr(vga_gc_pkg::IDX_MISC, 8'h01);
    // A register write with the clock enable low must be lost
    i_ce = 1'b0;
    reg_wr(vga_gc_pkg::IDX_MASK, 8'h00);
    i_ce = 1'b1;
    reg_rd(vga_gc_pkg::IDX_MASK, q);
    `CHK("frozen mask", 8'hFF, q)
    $display("test registers done");
    // planar setup only
    // Passes 16 to 19 wrap back to write mode 0, some with the bypass set
    for (int i = 0; i < 20; i++) begin
      cfg = '0;
      cfg.write_mode = 2'(i >> 2);
      cfg.function_select = 2'(i);
      cfg.rotate_count = 3'(i) ^ 3'h1;
      cfg.set_reset_enable = 4'(i) ^ 4'h7;
      cfg.set_reset_value = ~4'(i);
      cfg.plane_write_enable = 4'hF ^ 4'(i & 9);
      cfg.ext_sr_bypass = (i == 16 || i == 19);
      cfg.read_plane_select = 2'(i);
      lat = i[0] ? 4'h3 : 4'h0;
      mk = 8'hA5 ^ 8'(i * 17);
      reg_wr(vga_gc_pkg::IDX_MASK, mk);
      lt = u_mem.mem[16'h0100 + 16'(i)];
      mem_acc(1'b0, 17'h00100 + 17'(i), 8'h00, q);
      `CHK("plane read", lt[i[1:0]*8+:8], q)
      e = 8'h96 ^ 8'(i * 5);
      old = u_mem.mem[16'h0200 + 16'(i)];
      mem_acc(1'b1, 17'h00200 + 17'(i), e, q);
      w = u_mem.mem[16'h0200 + 16'(i)];
      `CHK("write planes", ref_wr(old, lt, cfg, mk, e), w)
    end
    $display("test write modes done");
    cfg = '0;
    cfg.read_mode = 1'b1;
    for (int j = 0; j < 4; j++) begin
      cfg.compare_color_value = 4'(j * 5);
      reg_wr(vga_gc_pkg::IDX_CMP, 8'h0F >> j);
      w = u_mem.mem[16'h0300 + 16'(j)];
      for (int b = 0; b < 8; b++) begin
        e[b] = 1'b1;
        for (int p = 0; p < 4; p++) begin
          if (p < 4 - j && w[p*8+b] !== cfg.compare_color_value[p]) e[b] = 1'b0;
        end
      end
      mem_acc(1'b0, 17'h00300 + 17'(j), 8'h00, q);
      `CHK("compare read", e, q)
    end
    $display("test compare done");
    cfg = '0;
    cfg.plane_write_enable = 4'hF;
    cfg.ext_sr_bypass = 1'b1;
    reg_wr(vga_gc_pkg::IDX_MASK, 8'hFF);
    reg_wr(vga_gc_pkg::IDX_MISC, 8'h03);
    old = u_mem.mem[16'h0020];
    mem_acc(1'b1, 17'h00021, 8'h3C, q);
    `CHK("odd chain", {8'h3C, old[23:16], 8'h3C, old[7:0]}, u_mem.mem[16'h0020])
    old = u_mem.mem[16'h0021];
    mem_acc(1'b1, 17'h10020, 8'hC3, q);
    `CHK("even chain", {old[31:24], 8'hC3, old[15:8], 8'hC3}, u_mem.mem[16'h0021])
    cfg.read_plane_select = 2'h2;
    mem_acc(1'b0, 17'h00021, 8'h00, q);
    `CHK("chain read", 8'h3C, q)
    $display("test chain done");
    for (int m = 0; m < 4; m++) begin
      reg_wr(vga_gc_pkg::IDX_MISC, {4'h0, 2'(m), 2'h1});
      for (int k = 0; k < 3; k++) begin
        i_mem_addr = hadr[m*3+k];
        #1;
        `CHK("aperture hit", hexp[m*3+k], o_mem_hit)
        @(negedge i_mclk);
      end
    end
    old = u_mem.mem[16'h0000];
    mem_acc(1'b1, 17'h00000, 8'h77, q);
    `CHK("miss ignored", old, u_mem.mem[16'h0000])
    $display("test aperture done");
    close_out();
  end
endmodule

// ==== verif/vram_plane_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Four-plane display memory behind the datapath
// ------------------------------------------------------------
module vram_plane_model (
  input wire logic i_mclk,
  input wire vga_gc_pkg::vram_req_t i_vram,
  input wire logic [3:0] i_lat,
  output logic [31:0] o_rdata,
  output logic o_rvalid
);
  logic [31:0] mem [0:65535];
  logic [15:0] raddr_q;
  int wait_q;

  // Varied preload so that stale plane data never looks correct
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = {a[7:0] ^ 8'h5A, a[15:8], ~a[7:0], a[7:0] + 8'h33};
    end
    o_rvalid = 1'b0;
    o_rdata = 32'h0;
    wait_q = -1;
  end

  // Bit-masked plane writes, reads answered after a chosen delay
  always @(posedge i_mclk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~o_rdata; // Idle data bus inverts each cycle, so the last word shows on alternate cycles
    if (i_vram.wr) begin
      for (int p = 0; p < 4; p++) begin
        if (i_vram.plane_en[p]) begin
          mem[i_vram.addr][p*8+:8] = (mem[i_vram.addr][p*8+:8] & ~i_vram.bit_mask) |
            (i_vram.data[p*8+:8] & i_vram.bit_mask);
        end
      end
    end
    if (i_vram.rd) begin
      raddr_q <= i_vram.addr;
      wait_q <= int'(i_lat);
    end else if (wait_q == 0) begin
      o_rvalid <= 1'b1;
      o_rdata <= mem[raddr_q];
      wait_q <= -1;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule
